// ### design/tec_pkg.sv
// package for the timer and external-interrupt control register
// assumes one cpu clock domain and an sfr bus with byte-wide data
package tec_pkg;

   // ------------------------------------------------
   // register address and reset
   // ------------------------------------------------
   localparam logic [7:0] TEC_ADDR = 8'h88; // sfr address of the control register
   localparam logic [7:0] TEC_RESET = 8'h00; // every field resets to zero

   // ------------------------------------------------
   // field positions
   // ------------------------------------------------
   localparam int TEC_T1_OVF = 7; // timer 1 overflow flag
   localparam int TEC_T1_RUN = 6; // timer 1 run
   localparam int TEC_T0_OVF = 5; // timer 0 overflow flag
   localparam int TEC_T0_RUN = 4; // timer 0 run
   localparam int TEC_X1_REQ = 3; // external 1 request flag
   localparam int TEC_X1_TRG = 2; // external 1 trigger select
   localparam int TEC_X0_REQ = 1; // external 0 request flag
   localparam int TEC_X0_TRG = 0; // external 0 trigger select

   // ------------------------------------------------
   // carriers
   // ------------------------------------------------
   // sfr access from the core
   typedef struct packed {
      logic [7:0] addr; // sfr address
      logic wr; // write strobe, one cycle
      logic [7:0] wdata; // write data
   } tec_sfr_t;

   // per-source events: overflows and vector acknowledges
   typedef struct packed {
      logic t1; // timer 1
      logic t0; // timer 0
      logic x1; // external 1
      logic x0; // external 0
   } tec_evt_t;

endpackage : tec_pkg

// ### design/tec_control.sv
// timer and external-interrupt control/status register, 8 bits at sfr 0x88
// assumes a synchronous core bus and pins already synchronous to clk_sys
`timescale 1ns/1ps

module tec_control
(
   input wire logic clk_sys, // cpu clock
   input wire logic reset_n, // async reset, active low
   input tec_pkg::tec_sfr_t sfr, // core sfr write access
   input wire logic [7:0] sfr_raddr, // core sfr read address
   output logic [7:0] sfr_rdata, // read data, zero when not addressed
   output logic sfr_rsel, // high when read address hits this register
   input tec_pkg::tec_evt_t overflow, // one-cycle timer overflow pulses (t1,t0)
   input tec_pkg::tec_evt_t vector_ack, // one-cycle vector pulses per source
   input wire logic ext_irq1_pin, // external interrupt 1, active low
   input wire logic ext_irq0_pin, // external interrupt 0, active low
   output logic timer1_run, // timer 1 may count
   output logic timer0_run, // timer 0 may count
   output logic [7:0] timer_extint_control // register contents to interrupt logic
);

   // ------------------------------------------------
   // state
   // ------------------------------------------------
   logic [7:0] ctl_reg; // stored bits; level-mode request bits unused
   logic [7:0] ctl_next; // next stored value
   logic irq1_prev_reg; // last pin 1 sample
   logic irq0_prev_reg; // last pin 0 sample

   // ------------------------------------------------
   // decode
   // ------------------------------------------------
   wire wr_hit = sfr.wr && (sfr.addr == tec_pkg::TEC_ADDR); // write to us
   wire trg1 = ctl_reg[tec_pkg::TEC_X1_TRG];
   wire trg0 = ctl_reg[tec_pkg::TEC_X0_TRG];

   // ------------------------------------------------
   // pin edge detection
   // ------------------------------------------------
   // the history flops reset high, the idle level of the active-low pins,
   // so leaving reset with a pin high never looks like an edge
   wire fall1 = irq1_prev_reg && !ext_irq1_pin;
   wire fall0 = irq0_prev_reg && !ext_irq0_pin;

   // ------------------------------------------------
   // software values for the flags
   // ------------------------------------------------
   // a write loads these bits into the flags; a one sets, a zero clears
   wire wbit_t1 = sfr.wdata[tec_pkg::TEC_T1_OVF]; // timer 1 flag value
   wire wbit_t0 = sfr.wdata[tec_pkg::TEC_T0_OVF]; // timer 0 flag value
   wire wbit_x1 = sfr.wdata[tec_pkg::TEC_X1_REQ]; // pin 1 request value
   wire wbit_x0 = sfr.wdata[tec_pkg::TEC_X0_REQ]; // pin 0 request value

   // latching flag update shared by all four flags; priority rises from
   // vector clear to software write to hardware set, so an event that
   // lands with a clear in the same cycle is never lost
   function automatic logic flag_next(input logic cur, input logic set,
                                      input logic wr, input logic wbit,
                                      input logic ack);
      logic v;
      v = cur;
      if (ack)
         v = 1'b0;
      if (wr)
         v = wbit;
      if (set)
         v = 1'b1;
      return v;
   endfunction : flag_next

   // next value of every stored bit
   always_comb
   begin
      ctl_next = ctl_reg;
      if (wr_hit)
      begin
         // run and trigger bits are plain software bits
         ctl_next[tec_pkg::TEC_T1_RUN] = sfr.wdata[tec_pkg::TEC_T1_RUN];
         ctl_next[tec_pkg::TEC_T0_RUN] = sfr.wdata[tec_pkg::TEC_T0_RUN];
         ctl_next[tec_pkg::TEC_X1_TRG] = sfr.wdata[tec_pkg::TEC_X1_TRG];
         ctl_next[tec_pkg::TEC_X0_TRG] = sfr.wdata[tec_pkg::TEC_X0_TRG];
      end
      // timer flags: overflow sets, a write loads, a vector clears
      ctl_next[tec_pkg::TEC_T1_OVF] = flag_next(ctl_reg[tec_pkg::TEC_T1_OVF],
         overflow.t1, wr_hit, wbit_t1, vector_ack.t1);
      ctl_next[tec_pkg::TEC_T0_OVF] = flag_next(ctl_reg[tec_pkg::TEC_T0_OVF],
         overflow.t0, wr_hit, wbit_t0, vector_ack.t0);
      // edge latches; in level mode the latch is held clear, so a later
      // switch to edge mode starts from a clean flag and never reports an
      // edge that was seen while the pin was only being mirrored
      ctl_next[tec_pkg::TEC_X1_REQ] = trg1 && flag_next(ctl_reg[tec_pkg::TEC_X1_REQ],
         fall1, wr_hit, wbit_x1, vector_ack.x1);
      ctl_next[tec_pkg::TEC_X0_REQ] = trg0 && flag_next(ctl_reg[tec_pkg::TEC_X0_REQ],
         fall0, wr_hit, wbit_x0, vector_ack.x0);
   end

   // register and pin history; the history flops reset to the idle high
   // level so that no false edge follows reset
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctl_reg <= tec_pkg::TEC_RESET;
         irq1_prev_reg <= 1'b1;
         irq0_prev_reg <= 1'b1;
      end
      else
      begin
         ctl_reg <= ctl_next;
         irq1_prev_reg <= ext_irq1_pin;
         irq0_prev_reg <= ext_irq0_pin;
      end
   end

   // ------------------------------------------------
   // visible value
   // ------------------------------------------------
   logic [7:0] view; // value seen by reads and interrupt logic
   // in level mode the request bits mirror the inverted pins directly, so
   // the stored latch bit is ignored there and a write to it has no effect
   always_comb
   begin
      view = ctl_reg;
      if (!trg1)
         view[tec_pkg::TEC_X1_REQ] = !ext_irq1_pin;
      if (!trg0)
         view[tec_pkg::TEC_X0_REQ] = !ext_irq0_pin;
   end

   // ------------------------------------------------
   // outputs
   // ------------------------------------------------
   // the run bits go straight from the flops, so a timer halts or starts
   // on the cycle after the write that changes its bit
   assign timer1_run = ctl_reg[tec_pkg::TEC_T1_RUN];
   assign timer0_run = ctl_reg[tec_pkg::TEC_T0_RUN];
   assign timer_extint_control = view;
   // reads are combinational; an unaddressed read returns zero
   assign sfr_rsel = (sfr_raddr == tec_pkg::TEC_ADDR);
   assign sfr_rdata = sfr_rsel ? view : 8'h00;

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   // timer 1 flag
   a_t1_ovf_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      overflow.t1 |=> ctl_reg[tec_pkg::TEC_T1_OVF])
      else $error("timer 1 overflow not flagged");
   a_t1_ack_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      vector_ack.t1 && !overflow.t1 && !wr_hit |=> !ctl_reg[tec_pkg::TEC_T1_OVF])
      else $error("timer 1 flag not cleared on vector");
   a_t1_wr_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_hit && !wbit_t1 && !overflow.t1 |=> !ctl_reg[tec_pkg::TEC_T1_OVF])
      else $error("timer 1 flag not cleared by write");

   // timer 0 flag
   a_t0_ovf_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      overflow.t0 |=> ctl_reg[tec_pkg::TEC_T0_OVF])
      else $error("timer 0 overflow not flagged");
   a_t0_wr_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_hit && !wbit_t0 && !overflow.t0 |=> !ctl_reg[tec_pkg::TEC_T0_OVF])
      else $error("timer 0 flag not cleared by write");
   a_t0_ack_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      vector_ack.t0 && !overflow.t0 && !wr_hit |=> !ctl_reg[tec_pkg::TEC_T0_OVF])
      else $error("timer 0 flag not cleared on vector");

   // run bits change only through a write
   a_run_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_hit |=> timer1_run == $past(sfr.wdata[tec_pkg::TEC_T1_RUN])
         && timer0_run == $past(sfr.wdata[tec_pkg::TEC_T0_RUN]))
      else $error("run bits do not follow write");
   a_t1_run_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !wr_hit |=> $stable(timer1_run))
      else $error("timer 1 run changed without write");
   a_t0_run_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !wr_hit |=> $stable(timer0_run))
      else $error("timer 0 run changed without write");

   // pin 1 request
   a_x1_edge: assert property (@(posedge clk_sys) disable iff (!reset_n)
      trg1 && !wr_hit && fall1 |=> view[tec_pkg::TEC_X1_REQ] || !trg1)
      else $error("pin 1 falling edge not latched");
   a_x1_no_rise: assert property (@(posedge clk_sys) disable iff (!reset_n)
      trg1 && !wr_hit && !ctl_reg[tec_pkg::TEC_X1_REQ] && !$fell(ext_irq1_pin)
         |=> !ctl_reg[tec_pkg::TEC_X1_REQ])
      else $error("pin 1 request set without falling edge");
   a_x1_ack_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      trg1 && vector_ack.x1 && !wr_hit && !$fell(ext_irq1_pin)
         |=> !ctl_reg[tec_pkg::TEC_X1_REQ])
      else $error("pin 1 request not cleared on vector");
   a_x1_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !trg1 && sfr_rsel |-> sfr_rdata[tec_pkg::TEC_X1_REQ] == !ext_irq1_pin)
      else $error("pin 1 level not reflected");
   a_x1_lvl_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !trg1 |=> !ctl_reg[tec_pkg::TEC_X1_REQ])
      else $error("pin 1 latch not held clear in level mode");

   // pin 0 request
   a_x0_edge: assert property (@(posedge clk_sys) disable iff (!reset_n)
      trg0 && !wr_hit && $fell(ext_irq0_pin) |=> ctl_reg[tec_pkg::TEC_X0_REQ])
      else $error("pin 0 falling edge not latched");
   a_x0_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      trg0 && view[tec_pkg::TEC_X0_REQ] && !wr_hit && !vector_ack.x0
         |=> view[tec_pkg::TEC_X0_REQ] || !trg0)
      else $error("pin 0 request dropped");
   a_x0_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !trg0 && sfr_rsel |-> sfr_rdata[tec_pkg::TEC_X0_REQ] == !ext_irq0_pin)
      else $error("pin 0 level not reflected");
   a_x0_lvl_clr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !trg0 |=> !ctl_reg[tec_pkg::TEC_X0_REQ])
      else $error("pin 0 latch not held clear in level mode");

endmodule : tec_control

// ### verification/tec_timer_model.sv
// timer counter model: counts while its run bit is high, pulses overflow
// assumes the run outputs of tec_control on the same clk_sys
`timescale 1ns/1ps
module tec_timer_model
#(
   parameter int MAX = 3 // short roll-over count
)
(
   input wire logic clk_sys, // cpu clock
   input wire logic reset_n, // async reset, active low
   input wire logic [1:0] run, // {timer 1, timer 0} run
   output tec_pkg::tec_evt_t ovf // one-cycle overflow pulses
);
   logic [1:0][3:0] cnt_reg; // per-timer count
   // a halted timer holds its count and never overflows
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_reg <= '0;
         ovf <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (run[i]) cnt_reg[i] <= (cnt_reg[i] == MAX) ? 4'h0 : cnt_reg[i] + 4'h1;
         end
         ovf <= {run[1] && cnt_reg[1] == MAX, run[0] && cnt_reg[0] == MAX, 2'b00};
      end
   end
endmodule : tec_timer_model

// ### verification/timer_extint_control_reg_bench.sv
// bench for the timer and external-interrupt control register
// assumes tec_timer_model as the timers; pins and core bus driven here
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module timer_extint_control_reg_bench;
   logic clk_sys = 1'b0; // cpu clock
   logic reset_n = 1'b0; // reset, active low
   tec_pkg::tec_sfr_t sfr = '0; // write access
   logic [7:0] sfr_raddr = 8'h00; // read address
   logic [7:0] sfr_rdata, timer_extint_control; // read data and view
   logic sfr_rsel, timer1_run, timer0_run; // hit and run outputs
   tec_pkg::tec_evt_t ovf; // overflow pulses from the model
   tec_pkg::tec_evt_t vector_ack = '0; // vector pulses
   logic ext_irq1_pin = 1'b1; // pins idle high
   logic ext_irq0_pin = 1'b1;
   int error_cnt = 0;
   int tests_run = 0;
   tec_control dut (.clk_sys(clk_sys), .reset_n(reset_n), .sfr(sfr), .sfr_raddr(sfr_raddr),
      .sfr_rdata(sfr_rdata), .sfr_rsel(sfr_rsel), .overflow(ovf), .vector_ack(vector_ack),
      .ext_irq1_pin(ext_irq1_pin), .ext_irq0_pin(ext_irq0_pin), .timer1_run(timer1_run),
      .timer0_run(timer0_run), .timer_extint_control(timer_extint_control));
   tec_timer_model #(.MAX(3)) timers (.clk_sys(clk_sys), .reset_n(reset_n),
      .run({timer1_run, timer0_run}), .ovf(ovf));
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end
   // ------------------------------------------------
   // access tasks, entered 1 ns after a rising edge
   // ------------------------------------------------
   task automatic step(input int n); repeat (n) @(posedge clk_sys); #1; endtask : step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{addr: a, wr: 1'b1, wdata: d};
      step(1);
      sfr.wr = 1'b0;
      step(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_raddr = a;
      #1;
      `CHK(sfr_rdata, e)
      `CHK(sfr_rsel, (a == tec_pkg::TEC_ADDR))
      step(1);
   endtask : rd
   task automatic vec(input tec_pkg::tec_evt_t v);
      vector_ack = v;
      step(1);
      vector_ack = '0;
      step(1);
   endtask : vec
   task automatic test_done;
      $display("mismatches %0d, checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      int k;
      step(10);
      reset_n = 1'b1;
      step(1);
      rd(8'h88, 8'h00);
      rd(8'h89, 8'h00);
      wr(8'h88, 8'h50);
      `CHK({timer1_run, timer0_run}, 2'b11)
      for (k = 0; k < 20 && timer_extint_control[7:5] != 3'h7; k++) step(1);
      `CHK(timer_extint_control[7:5], 3'h7)
      wr(8'h88, 8'ha0);
      step(8);
      rd(8'h88, 8'ha0);
      wr(8'h88, 8'h80);
      rd(8'h88, 8'h80);
      vec(4'b1000);
      step(8);
      rd(8'h88, 8'h00);
      wr(8'h88, 8'h20);
      vec(4'b0100);
      rd(8'h88, 8'h00);
      ext_irq1_pin = 1'b0;
      rd(8'h88, 8'h08);
      ext_irq0_pin = 1'b0;
      wr(8'h88, 8'h00);
      rd(8'h88, 8'h0a);
      ext_irq1_pin = 1'b1;
      ext_irq0_pin = 1'b1;
      wr(8'h88, 8'h0a);
      rd(8'h88, 8'h00);
      wr(8'h88, 8'h05);
      ext_irq1_pin = 1'b0;
      step(3);
      ext_irq1_pin = 1'b1;
      step(2);
      rd(8'h88, 8'h0d);
      ext_irq0_pin = 1'b0;
      step(1);
      ext_irq0_pin = 1'b1;
      step(2);
      rd(8'h88, 8'h0f);
      vec(4'b0010);
      rd(8'h88, 8'h07);
      wr(8'h89, 8'hff);
      rd(8'h88, 8'h07);
      wr(8'h88, 8'h05);
      `CHK(timer_extint_control, 8'h05)
      wr(8'h88, 8'h01);
      ext_irq1_pin = 1'b0;
      rd(8'h88, 8'h09);
      wr(8'h88, 8'h05);
      ext_irq1_pin = 1'b1;
      step(2);
      rd(8'h88, 8'h05);
      test_done();
   end
endmodule : timer_extint_control_reg_bench
